// file: dv/ext_clock_source.sv
// Behavioural external count clock source that idles low between bursts
module ext_clock_source #(
  parameter int HALF = 8
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [4:0] n_i,
  output logic            pin_o,
  output logic            busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int edges;
  int tick;

  // Send n rising edges, HALF cycles per level, then stand still low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edges <= 0;
      tick  <= 0;
      pin_o <= 1'b0;
    end else if (go_i) begin
      edges <= 2 * int'(n_i);
      tick  <= 0;
    end else if (edges > 0) begin
      tick <= tick + 1;
      if (tick == HALF - 1) begin
        pin_o <= ~pin_o;
        edges <= edges - 1;
        tick  <= 0;
      end
    end
  end
  assign busy_o = (edges > 0);
endmodule // ext_clock_source

// file: dv/gated_16bit_timer_tb.sv
// Self-checking testbench of the gated 16-bit timer
module gated_16bit_timer_tb;
  import timer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             cyc, stb, we, gate_n, go, pin, busy;
  logic [ADR_W-1:0] adr;
  logic [DAT_W-1:0] wdat, dat_o;
  logic [4:0]       nn;
  logic [3:0]       sel;
  logic             ack_o, lp_run, pins_in, flag_o, irq_o, wake_o;
  logic [7:0]       v, w;
  int               n_fail = 0;
  int               tests_run = 0;
  int               n;
  // Row table: control byte, misc byte, rises counted (0 none, 1 all but first, 2 all)
  // The oscillator input is the inverted burst, so its first edge is a fall
  localparam logic [7:0] CTL_T [7] = '{8'h07, 8'h03, 8'h07, 8'h03, 8'h0F, 8'h0F, 8'h07};
  localparam logic [7:0] MSC_T [7] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h00, 8'h01, 8'h04};
  localparam int         CNT_T [7] = '{1, 1, 1, 0, 1, 2, 0};

  // Clock at 250 MHz
  always #2 clk_i = ~clk_i;

  gated_16bit_timer gated_16bit_timer_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .ext_count_clock_pin_i(pin), .lp_osc_clk_i(~pin), .gate_pin_n_i(gate_n),
    .lp_osc_run_o(lp_run), .osc_pins_input_o(pins_in), .overflow_flag_o(flag_o),
    .irq_o(irq_o), .wake_o(wake_o));

  ext_clock_source ext_clock_source_i (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .n_i(nn), .pin_o(pin), .busy_o(busy));

  // ----------------------------------------------------------------------
  // Bus cycles, pulse bursts and comparisons
  // ----------------------------------------------------------------------
  task automatic wb(input logic wr_en, input logic [7:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= wr_en;
    adr  <= {idx, 2'b00};
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    v = dat_o[7:0];
    if (k >= 50) n_fail++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx);
    wb(1'b0, idx, 8'h00);
  endtask

  task automatic pulse(input int cnt);
    int k;
    k = 0;
    go <= 1'b1;
    nn <= 5'(cnt);
    @(posedge clk_i);
    go <= 1'b0;
    do begin
      @(posedge clk_i);
      k++;
    end while (busy !== 1'b0 && k < 1000);
    if (k >= 1000) n_fail++;
    repeat (20) @(posedge clk_i);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Timer-mode counts may differ by one tick from bus latency
  task automatic chk_near(input logic [7:0] got, input int exp);
    tests_run++;
    if (^got === 1'bx || int'(got) + 1 < exp || int'(got) > exp + 1) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic int ticks(input int cycles, input int ps);
    return cycles / (INSTR_DIV << ps);
  endfunction

  // Expected external count from the row code and the number of rises sent
  function automatic logic [7:0] ext_count(input int code, input int rises);
    return (code == 0) ? 8'h00 : 8'(rises - 2 + code);
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge clk_i);
    n_fail++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {cyc, stb, we, go, gate_n} = 5'b00001;
    adr  = '0;
    wdat = '0;
    nn   = '0;
    sel  = 4'hF;
    void'($urandom(32'ha756_5ef8));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(IDX_CTRL); chk(v, 8'h00);
    wr(IDX_CTRL, 8'h80); rd(IDX_CTRL); chk(v, 8'h00);
    rd(8'h30); chk(v, 8'h00);
    // Random count values written and read back while stopped
    for (int i = 0; i < 4; i++) begin
      w = 8'($urandom);
      wr(IDX_CNT_LO, w); wr(IDX_CNT_HI, ~w);
      rd(IDX_CNT_LO); chk(v, w);
      rd(IDX_CNT_HI); chk(v, ~w);
    end
    // A write without byte lane zero is ignored
    sel <= 4'hE;
    wr(IDX_CNT_LO, ~w);
    sel <= 4'hF;
    rd(IDX_CNT_LO); chk(v, w);
    // Internal clock through every prescale code, then hold when off
    for (int ps = 0; ps < 4; ps++) begin
      wr(IDX_CNT_LO, 8'h00); wr(IDX_CNT_HI, 8'h00);
      wr(IDX_CTRL, 8'(8'h01 | (ps << 4)));
      repeat (256) @(posedge clk_i);
      wr(IDX_CTRL, 8'(ps << 4));
      rd(IDX_CNT_LO); chk_near(v, ticks(256, ps));
      w = v;
      repeat (40) @(posedge clk_i);
      rd(IDX_CNT_LO); chk(v, w);
    end
    // Gate: enabled and high blocks, enabled and low counts, disabled counts,
    // enabled with an analog gate pin counts
    for (int j = 0; j < 4; j++) begin
      gate_n <= (j != 1);
      wr(IDX_MISC, (j == 3) ? 8'h08 : 8'h00);
      wr(IDX_CNT_LO, 8'h00); wr(IDX_CNT_HI, 8'h00);
      repeat (8) @(posedge clk_i);
      wr(IDX_CTRL, (j == 2) ? 8'h01 : 8'h41);
      repeat (64) @(posedge clk_i);
      wr(IDX_CTRL, 8'h00);
      rd(IDX_CNT_LO); chk_near(v, (j == 0) ? 0 : ticks(64, 0));
    end
    gate_n <= 1'b1;
    // Rollover with interrupt enables off, then all on
    for (int e = 0; e < 2; e++) begin
      wr(IDX_FLAG, 8'h00); wr(IDX_CNT_LO, 8'hFE); wr(IDX_CNT_HI, 8'hFF);
      wr(IDX_ENABLE, 8'(e)); wr(IDX_INTCTL, e ? 8'hC0 : 8'h00);
      wr(IDX_CTRL, 8'h01);
      repeat (40) @(posedge clk_i);
      chk({7'h00, flag_o}, 8'h01);
      chk({7'h00, irq_o}, 8'(e));
      chk({7'h00, wake_o}, 8'(e));
      rd(IDX_CNT_HI); chk(v, 8'h00);
      wr(IDX_CTRL, 8'h00);
      repeat (100) @(posedge clk_i);
      chk({7'h00, flag_o}, 8'h01);
      wr(IDX_FLAG, 8'h00); chk({7'h00, flag_o}, 8'h00);
    end
    wr(IDX_ENABLE, 8'h00); wr(IDX_INTCTL, 8'h00);
    // External pin bursts; the first rise from an idle low pin is not counted
    for (int r = 0; r < 7; r++) begin
      wr(IDX_CTRL, 8'h00); wr(IDX_MISC, MSC_T[r]);
      wr(IDX_CNT_LO, 8'h00); wr(IDX_CNT_HI, 8'h00);
      wr(IDX_CTRL, CTL_T[r]);
      chk({7'h00, lp_run}, 8'(CTL_T[r][3] & MSC_T[r][0]));
      chk({7'h00, pins_in}, 8'(CTL_T[r][3] & MSC_T[r][0]));
      n = 2 + int'($urandom % 8);
      pulse(n);
      rd(IDX_CNT_LO); chk(v, ext_count(CNT_T[r], n));
    end
    // Writing a count byte clears a partly filled divide-by-8 prescaler
    wr(IDX_CTRL, 8'h00); wr(IDX_MISC, 8'h00);
    wr(IDX_CNT_LO, 8'h00); wr(IDX_CNT_HI, 8'h00);
    wr(IDX_CTRL, 8'h37);
    pulse(5);
    wr(IDX_CNT_LO, 8'h00);
    pulse(5);
    rd(IDX_CNT_LO); chk(v, 8'h00);
    tally_and_finish;
  end
endmodule // gated_16bit_timer_tb

// file: rtl/gated_16bit_timer.sv
// Gated 16-bit timer/counter with Wishbone register access
//
// Summary of operation
// - Count to FFFFh, wrap to zero, set flag
// - Source select: Fosc/4 or external clock pin
// - Timer per instruction cycle; counter per rise
// - First rise counts only after a fall
// - Gate enable: count only while gate low
// - Prescale codes divide by 1, 2, 4, 8
// - Prescaler hidden; count byte writes clear it
// - LP oscillator used only with internal oscillator
// - Sync bit: synchronise or bypass external clock
// - Timer-on bit stops and holds count
// - Unsynchronised counting runs and wakes in sleep
// - Analog-configured pins read as zero
// - Low and high count bytes at 0Eh/0Fh
// - Oscillator enabled: pins forced input, read zero
module gated_16bit_timer
  import timer_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [DAT_W-1:0] dat_i,
  output logic      [DAT_W-1:0] dat_o,
  output logic                  ack_o,
  input  wire logic             ext_count_clock_pin_i,
  input  wire logic             lp_osc_clk_i,
  input  wire logic             gate_pin_n_i,
  output logic                  lp_osc_run_o,
  output logic                  osc_pins_input_o,
  output logic                  overflow_flag_o,
  output logic                  irq_o,
  output logic                  wake_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0]      cnt;
    logic [6:0]       ctrl;
    logic [3:0]       misc;
    logic             flag;
    logic             ie;
    logic             peripheral_irq_enable;
    logic             global_irq_enable;
    logic [1:0]       phase;
    logic             ext_prev;
    logic             armed;
    logic             pend;
    logic             ack;
    logic [DAT_W-1:0] rdat;
  } timer_state_type;

  timer_state_type st_r;
  timer_state_type st_nxt;

  logic [PIN_NUM-1:0] pin_lvl;
  logic [7:0]         idx;
  logic               hit;
  logic               wr;
  logic               cnt_wr;
  logic               osc_eff;
  logic               ext_lvl;
  logic               gate_lvl_n;
  logic               itick;
  logic               rise;
  logic               fall;
  logic               src_ext;
  logic               bypass;
  logic               run;
  logic               raw_tick;
  logic               inc;
  logic               wrap;
  logic [7:0]         rd_byte;

  // ----------------------------------------------------------------------
  // Pin synchronisers and prescaler
  // ----------------------------------------------------------------------
  pin_sync #(
    .W (PIN_NUM)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i ({gate_pin_n_i, lp_osc_clk_i, ext_count_clock_pin_i}),
    .lvl_o (pin_lvl)
  );

  prescaler u_presc (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (raw_tick && run),
    .clr_i  (cnt_wr),
    .sel_i  (st_r.ctrl[BIT_PS_HI:BIT_PS_LO]),
    .out_o  (inc)
  );

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  assign idx    = reg_idx(adr_i);
  assign hit    = cyc_i && stb_i && !st_r.ack;
  assign wr     = hit && we_i && sel_i[0];
  assign cnt_wr = wr && (idx == IDX_CNT_LO || idx == IDX_CNT_HI);

  // Clock source selection and pin conditioning
  assign osc_eff    = st_r.ctrl[BIT_OSC] && st_r.misc[BIT_INTERNAL_OSCILLATOR];
  assign ext_lvl    = osc_eff ? pin_lvl[PIN_OSC] :
                      (st_r.misc[BIT_CKI_ANA] ? 1'b0 : pin_lvl[PIN_CKI]);
  assign gate_lvl_n = st_r.misc[BIT_GATE_ANA] ? 1'b0 : pin_lvl[PIN_GATE];
  assign src_ext    = st_r.ctrl[BIT_CS];
  assign bypass     = st_r.ctrl[BIT_SYNC];

  // Instruction-cycle tick; system clock halts in sleep
  assign itick = (st_r.phase == INSTR_LAST) && !st_r.misc[BIT_SLEEP];

  // Edge detection on the conditioned external clock
  assign rise = ext_lvl && !st_r.ext_prev;
  assign fall = !ext_lvl && st_r.ext_prev;

  // Count clock: internal, synchronised or bypassed external
  always_comb begin
    if (!src_ext) begin
      raw_tick = itick;
    end else if (bypass) begin
      raw_tick = rise && st_r.armed;
    end else begin
      raw_tick = st_r.pend && itick;
    end
  end

  // Timer on, optionally gated by the active-low gate pin
  assign run  = st_r.ctrl[BIT_ON] &&
                (!st_r.ctrl[BIT_GE] || !gate_lvl_n);
  assign wrap = inc && (st_r.cnt == MAX_COUNT);

  // Read data mux
  always_comb begin
    case (idx)
      IDX_CNT_LO: rd_byte = st_r.cnt[7:0];
      IDX_CNT_HI: rd_byte = st_r.cnt[15:8];
      IDX_CTRL:   rd_byte = {1'b0, st_r.ctrl};
      IDX_FLAG:   rd_byte = {7'h00, st_r.flag};
      IDX_ENABLE: rd_byte = {7'h00, st_r.ie};
      IDX_INTCTL: rd_byte = {st_r.global_irq_enable, st_r.peripheral_irq_enable, 6'h00};
      IDX_MISC:   rd_byte = {4'h0, st_r.misc};
      default:    rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.ack      = hit;
    st_nxt.ext_prev = ext_lvl;
    // Instruction phase counter
    if (!st_r.misc[BIT_SLEEP]) begin
      st_nxt.phase = st_r.phase + 2'h1;
    end
    // Arm on a falling edge; disarm outside counter mode
    if (!src_ext || !st_r.ctrl[BIT_ON]) begin
      st_nxt.armed = 1'b0;
    end else if (fall) begin
      st_nxt.armed = 1'b1;
    end
    // Rising edge waits for the next instruction cycle
    st_nxt.pend = (rise && st_r.armed) || (st_r.pend && !itick);
    // Read data for the answer
    if (hit && !we_i) begin
      st_nxt.rdat = {24'h00_0000, rd_byte};
    end else begin
      st_nxt.rdat = '0;
    end
    // Counter advance; a byte write takes precedence
    if (inc) begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
    if (wr) begin
      case (idx)
        IDX_CNT_LO: st_nxt.cnt[7:0]  = dat_i[7:0];
        IDX_CNT_HI: st_nxt.cnt[15:8] = dat_i[7:0];
        IDX_CTRL:   st_nxt.ctrl      = dat_i[6:0];
        IDX_ENABLE: st_nxt.ie        = dat_i[BIT_FLAG];
        IDX_MISC:   st_nxt.misc      = dat_i[3:0];
        IDX_FLAG:   st_nxt.flag      = dat_i[BIT_FLAG];
        IDX_INTCTL: begin
          st_nxt.global_irq_enable  = dat_i[BIT_GIE];
          st_nxt.peripheral_irq_enable = dat_i[BIT_PERIPHERAL_IRQ_ENABLE];
        end
        default: begin
        end
      endcase
    end
    // Overflow sets the flag and wins over a clear
    if (wrap) begin
      st_nxt.flag = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r      <= '0;
      st_r.ctrl <= CTRL_RST;
      st_r.misc <= MISC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign dat_o            = st_r.rdat;
  assign ack_o            = st_r.ack;
  assign lp_osc_run_o     = osc_eff;
  assign osc_pins_input_o = osc_eff;
  assign overflow_flag_o  = st_r.flag;
  // Wake needs flag, enable and peripheral enable; interrupt also global
  assign wake_o = st_r.flag && st_r.ie && st_r.peripheral_irq_enable;
  assign irq_o  = wake_o && st_r.global_irq_enable;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_wrap_sets_flag: assert property (wrap |=> st_r.flag)
    else $error("wrap did not set flag");

  chk_wrap_to_zero: assert property (
    (wrap && !cnt_wr) |=> (st_r.cnt == 16'h0000))
    else $error("count did not wrap to zero");

  chk_off_holds_count: assert property (
    (!st_r.ctrl[BIT_ON] && !cnt_wr) |=> $stable(st_r.cnt))
    else $error("stopped timer changed");

  chk_gate_blocks_count: assert property (
    (st_r.ctrl[BIT_GE] && gate_lvl_n && !cnt_wr) |=> $stable(st_r.cnt))
    else $error("count advanced with gate high");

  chk_write_clears_presc: assert property (cnt_wr |-> !inc)
    else $error("increment in write cycle");

  chk_unarmed_no_edge: assert property (
    (src_ext && bypass && !st_r.armed && !cnt_wr) |=> $stable(st_r.cnt))
    else $error("rise counted before fall");

  chk_instr_rate: assert property (
    itick |=> (!itick)[*3])
    else $error("instruction tick too fast");

  chk_flag_set_wins: assert property (
    (wrap && wr && idx == IDX_FLAG && !dat_i[BIT_FLAG]) |=> st_r.flag)
    else $error("flag clear beat overflow");

  chk_flag_sticky: assert property (
    (st_r.flag && !(wr && idx == IDX_FLAG)) |=> st_r.flag)
    else $error("flag cleared by hardware");

  chk_bit7_zero: assert property (
    (hit && !we_i && idx == IDX_CTRL) |=> (dat_o[7] == 1'b0))
    else $error("control bit 7 read as one");

  chk_osc_ignored: assert property (
    !st_r.misc[BIT_INTERNAL_OSCILLATOR] |-> !lp_osc_run_o)
    else $error("oscillator ran without internal clock");

  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");

  // Bus answers one cycle after the request and reads zero when idle
  chk_ack_follows_req: assert property (hit |=> ack_o)
    else $error("request not answered");

  chk_idle_data_zero: assert property (!ack_o |-> (dat_o == '0))
    else $error("read data not zero while idle");

  // Counting steps by one and respects the source and sleep state
  chk_count_step: assert property (
    (inc && !wrap) |=> (st_r.cnt == $past(st_r.cnt) + 16'h0001))
    else $error("count did not step by one");

  chk_internal_rate: assert property (
    (!src_ext && inc) |=> (!inc || src_ext)[*3])
    else $error("internal count faster than instruction rate");

  chk_ext_rise_once: assert property (
    (src_ext && bypass && inc) |=> (!inc || !bypass || !src_ext))
    else $error("one external rise counted twice");

  chk_sleep_stops_timer: assert property (
    (!src_ext && st_r.misc[BIT_SLEEP] && !cnt_wr) |=> $stable(st_r.cnt))
    else $error("timer mode counted in sleep");

  chk_sync_sleep_hold: assert property (
    (src_ext && !bypass && st_r.misc[BIT_SLEEP] && !cnt_wr) |=> $stable(st_r.cnt))
    else $error("synchronised count advanced in sleep");

  chk_analog_pin_zero: assert property (
    (st_r.misc[BIT_CKI_ANA] && !osc_eff) |=> !st_r.ext_prev)
    else $error("analog clock pin did not read zero");

  chk_osc_pins_input: assert property (
    (st_r.ctrl[BIT_OSC] && st_r.misc[BIT_INTERNAL_OSCILLATOR]) |-> osc_pins_input_o)
    else $error("oscillator pins not forced to input");

  // Flag clears on a write; interrupt and wake outputs follow an overflow
  chk_flag_clear: assert property (
    (wr && idx == IDX_FLAG && !dat_i[BIT_FLAG] && !wrap) |=> !st_r.flag)
    else $error("flag clear write ignored");

  chk_irq_on_wrap: assert property (
    (wrap && !wr && st_r.ie && st_r.peripheral_irq_enable && st_r.global_irq_enable) |=> irq_o)
    else $error("enabled overflow raised no interrupt");

  chk_wake_on_wrap: assert property (
    (wrap && !wr && st_r.ie && st_r.peripheral_irq_enable) |=> wake_o)
    else $error("enabled overflow raised no wake");

  cov_wrap:      cover property (wrap);
  cov_irq:       cover property (irq_o);
  cov_ext_count: cover property (src_ext && bypass && inc);
  cov_sleep_inc: cover property (st_r.misc[BIT_SLEEP] && inc);
  cov_gated_count: cover property (st_r.ctrl[BIT_GE] && !gate_lvl_n && inc);

endmodule // gated_16bit_timer

// file: rtl/pin_sync.sv
// Three-stage input synchroniser with agreement filter
module pin_sync
  import timer_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] lvl_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_state_type;

  sync_state_type st_r;
  sync_state_type st_nxt;

  // Shift chain; output moves only when stages two and three agree
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lvl_o = st_r.q;

endmodule // pin_sync

// file: rtl/prescaler.sv
// Count clock prescaler, divide by 1, 2, 4 or 8
module prescaler
  import timer_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic       clr_i,
  input  wire logic [1:0] sel_i,
  output logic            out_o
);

  typedef struct packed {
    logic [2:0] cnt;
  } presc_state_type;

  presc_state_type st_r;
  presc_state_type st_nxt;
  logic [2:0]      mask;

  // Divide; a clear suppresses the tick in the same cycle
  always_comb begin
    st_nxt = st_r;
    mask   = div_mask(sel_i);
    out_o  = tick_i && !clr_i && ((st_r.cnt & mask) == mask);
    if (clr_i) begin
      st_nxt.cnt = '0;
    end else if (tick_i) begin
      st_nxt.cnt = st_r.cnt + 3'h1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // prescaler

// file: rtl/timer_pkg.sv
// Constants, register map and field layout of the gated 16-bit timer
package timer_pkg;

  // ----------------------------------------------------------------------
  // Bus and register map (index; byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam int        ADR_W        = 10;
  localparam int        DAT_W        = 32;
  localparam logic [7:0] IDX_INTCTL  = 8'h0B;
  localparam logic [7:0] IDX_FLAG    = 8'h0C;
  localparam logic [7:0] IDX_CNT_LO  = 8'h0E;
  localparam logic [7:0] IDX_CNT_HI  = 8'h0F;
  localparam logic [7:0] IDX_CTRL    = 8'h10;
  localparam logic [7:0] IDX_MISC    = 8'h20;
  localparam logic [7:0] IDX_ENABLE  = 8'h8C;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int        BIT_ON       = 0;
  localparam int        BIT_CS       = 1;
  localparam int        BIT_SYNC     = 2;
  localparam int        BIT_OSC      = 3;
  localparam int        BIT_PS_LO    = 4;
  localparam int        BIT_PS_HI    = 5;
  localparam int        BIT_GE       = 6;
  localparam int        BIT_PERIPHERAL_IRQ_ENABLE     = 6;
  localparam int        BIT_GIE      = 7;
  localparam int        BIT_FLAG     = 0;
  localparam int        BIT_INTERNAL_OSCILLATOR   = 0;
  localparam int        BIT_SLEEP    = 1;
  localparam int        BIT_CKI_ANA  = 2;
  localparam int        BIT_GATE_ANA = 3;
  localparam logic [6:0] CTRL_RST    = 7'h00;
  localparam logic [3:0] MISC_RST    = 4'h0;
  localparam logic [15:0] MAX_COUNT  = 16'hFFFF;

  // ----------------------------------------------------------------------
  // Timing: internal count clock is the oscillator divided by four
  // ----------------------------------------------------------------------
  localparam int        FOSC_MHZ     = 250;
  localparam int        INSTR_DIV    = 4;
  localparam logic [1:0] INSTR_LAST  = 2'(INSTR_DIV - 1);

  // Synchronised pin vector positions
  localparam int        PIN_CKI      = 0;
  localparam int        PIN_OSC      = 1;
  localparam int        PIN_GATE     = 2;
  localparam int        PIN_NUM      = 3;

  // Prescale code to counter mask: 00 /1, 01 /2, 10 /4, 11 /8
  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    div_mask = 3'((4'h1 << sel) - 4'h1);
  endfunction

  // Byte address to register index
  function automatic logic [7:0] reg_idx(input logic [ADR_W-1:0] adr);
    reg_idx = adr[9:2];
  endfunction

endpackage
